// *** src/cmg_pkg.sv ***
package cmg_pkg;

  // ****************************************************************
  // Clock mode field layout
  // ****************************************************************
  localparam int unsigned MODE_W       = 8;
  localparam int unsigned MUL_INT_LSB  = 2;
  localparam int unsigned MUL_INT_W    = 4;
  localparam int unsigned MUL_FRAC_LSB = 0;
  localparam int unsigned MUL_FRAC_W   = 2;
  localparam int unsigned PLL_EN_BIT   = 6;
  localparam int unsigned DIV4_BIT     = 7;
  localparam logic [3:0]  MUL_MIN      = 4'h1;
  localparam logic [3:0]  MUL_MAX      = 4'hf;
  localparam logic [7:0]  MODE_RST     = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned LOCK_US      = 30;
  localparam int unsigned LOCK_CYC     = (LOCK_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W        = 12;

  typedef struct packed {
    logic       div4;
    logic       pll_en;
    logic [3:0] mul_int;
    logic [1:0] mul_frac;
  } cmg_mode_s;

  typedef enum logic [1:0] {
    ST_DIV  = 2'b00,
    ST_LOCK = 2'b01,
    ST_PLL  = 2'b10
  } cmg_state_e;

endpackage

// *** src/cmg_sync3.sv ***
`timescale 1ns/100ps
module cmg_sync3 (
  input  wire logic core_clk_i, // Core clock
  input  wire logic srst_i,     // Sync reset
  input  wire logic d_i,        // Asynchronous level
  output logic      q_o,        // Filtered level
  output logic      rise_o      // One-cycle pulse on accepted rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;
  wire  agree = (s2_ff == s3_ff);
  wire  nxt_q = agree ? s3_ff : q_ff;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_ff  <= 1'b0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign q_o    = q_ff;
  assign rise_o = nxt_q & ~q_ff;
endmodule

// *** src/cmg_clock_mode_gen.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Machine cycle derived from reference: divide by two or four, or multiply.
// - Clock mode register bits select the output to reference ratio.
// - PLL off, divide-by-two: machine period is twice reference period.
// - PLL on: machine period is reference period over N, N 1 to 15.
// - Multiplier also takes fractions .25, .5, .75; reference range narrows.
// - PLL locks within 30 us; output stays on the divider until LOCK_CYCLES have elapsed.
// - Divide modes fully static; state held with reference slowed or stopped.
module cmg_clock_mode_gen #(
  parameter int unsigned LOCK_CYCLES = cmg_pkg::LOCK_CYC
) (
  input  wire logic                       core_clk_i,       // Core clock
  input  wire logic                       srst_i,           // Sync reset
  input  wire logic                       ref_clock_pin_i,  // Reference pin
  input  wire logic                       pll_clk_i,        // PLL output pin
  input  wire logic                       mode_wr_i,        // Mode write strobe
  input  wire cmg_pkg::cmg_mode_s         mode_wdata_i,     // Mode write data
  output cmg_pkg::cmg_mode_s              clock_mode_register_o, // Mode
  output logic                            pll_run_o,        // PLL enable
  output logic                            pll_locked_o,     // Lock elapsed
  output logic                            machine_clock_output_o // Clock
);
  // Counter width bounds the lock interval
  if ((LOCK_CYCLES < 1) ||
      (LOCK_CYCLES >= (1 << cmg_pkg::CNT_W))) begin : g_bad_lock
    $error("LOCK_CYCLES out of range");
  end

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  logic ref_lvl;
  logic ref_rise;
  logic pll_lvl;

  cmg_sync3 u_ref_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .d_i        (ref_clock_pin_i),
    .q_o        (ref_lvl),
    .rise_o     (ref_rise)
  );

  cmg_sync3 u_pll_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .d_i        (pll_clk_i),
    .q_o        (pll_lvl),
    .rise_o     ()
  );

  // ****************************************************************
  // Clock mode register
  // ****************************************************************
  cmg_pkg::cmg_mode_s mode_ff;
  cmg_pkg::cmg_state_e state_ff;
  cmg_pkg::cmg_state_e nxt_state;
  logic [cmg_pkg::CNT_W-1:0] lock_cnt_ff;
  logic [cmg_pkg::CNT_W-1:0] nxt_lock_cnt;
  logic [1:0] div_cnt_ff;
  logic       clk_out_ff;
  logic       run_ff;
  logic       lock_ff;

  // Zero integer multiplier is not legal with PLL enabled; such writes are dropped
  wire mul_ok   = (mode_wdata_i.mul_int >= cmg_pkg::MUL_MIN) &&
                  (mode_wdata_i.mul_int <= cmg_pkg::MUL_MAX);
  wire mode_acc = mode_wr_i && (!mode_wdata_i.pll_en || mul_ok);
  wire pll_entry = mode_acc && mode_wdata_i.pll_en;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) mode_ff <= cmg_pkg::MODE_RST;
    else if (mode_acc) mode_ff <= mode_wdata_i;
  end

  // ****************************************************************
  // Lock sequencing
  // ****************************************************************
  wire cnt_done = (lock_cnt_ff == '0);

  always_comb begin
    nxt_state    = state_ff;
    nxt_lock_cnt = lock_cnt_ff;
    unique case (state_ff)
      cmg_pkg::ST_DIV: begin
        if (pll_entry) begin
          nxt_state    = cmg_pkg::ST_LOCK;
          nxt_lock_cnt = cmg_pkg::CNT_W'(LOCK_CYCLES - 1);
        end
      end
      cmg_pkg::ST_LOCK: begin
        if (mode_acc && !mode_wdata_i.pll_en) begin
          nxt_state = cmg_pkg::ST_DIV;
        end else if (pll_entry) begin
          nxt_lock_cnt = cmg_pkg::CNT_W'(LOCK_CYCLES - 1);
        end else if (cnt_done) begin
          nxt_state = cmg_pkg::ST_PLL;
        end else begin
          nxt_lock_cnt = lock_cnt_ff - 1'b1;
        end
      end
      cmg_pkg::ST_PLL: begin
        if (mode_acc && !mode_wdata_i.pll_en) begin
          nxt_state = cmg_pkg::ST_DIV;
        end else if (pll_entry) begin
          // New factor: relock before trusting the PLL again
          nxt_state    = cmg_pkg::ST_LOCK;
          nxt_lock_cnt = cmg_pkg::CNT_W'(LOCK_CYCLES - 1);
        end
      end
      default: begin
        nxt_state = cmg_pkg::ST_DIV;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff    <= cmg_pkg::ST_DIV;
      lock_cnt_ff <= '0;
      run_ff      <= 1'b0;
      lock_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      lock_cnt_ff <= nxt_lock_cnt;
      run_ff      <= (nxt_state != cmg_pkg::ST_DIV);
      lock_ff     <= (nxt_state == cmg_pkg::ST_PLL);
    end
  end

  // ****************************************************************
  // Clock output
  // ****************************************************************
  // Divider only advances on reference edges, so a stopped reference
  // freezes it in place with nothing lost
  wire [1:0] div_half = mode_ff.div4 ? 2'h1 : 2'h0;
  // At or past the wrap point, so a div4 to div2 change never overruns
  wire       div_wrap = (div_cnt_ff >= div_half);
  wire       on_pll   = (state_ff == cmg_pkg::ST_PLL);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      div_cnt_ff <= 2'h0;
      clk_out_ff <= 1'b0;
    end else if (on_pll) begin
      div_cnt_ff <= 2'h0;
      clk_out_ff <= pll_lvl;
    end else if (ref_rise) begin
      div_cnt_ff <= div_wrap ? 2'h0 : div_cnt_ff + 2'h1;
      if (div_wrap) clk_out_ff <= ~clk_out_ff;
    end
  end

  assign clock_mode_register_o  = mode_ff;
  assign pll_run_o              = run_ff;
  assign pll_locked_o           = lock_ff;
  assign machine_clock_output_o = clk_out_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  lock_wait_a: assert property (
    (state_ff == cmg_pkg::ST_DIV) && pll_entry |=> !lock_ff [*8])
    else $error("lock flagged too early");
  no_early_switch_a: assert property (
    !on_pll && !ref_rise |=> $stable(clk_out_ff))
    else $error("clock moved without reference edge");
  div2_toggle_a: assert property (
    !on_pll && !mode_ff.div4 && ref_rise |=> clk_out_ff != $past(clk_out_ff))
    else $error("divide by two missed a toggle");
  div_static_a: assert property (
    !on_pll && !ref_rise |=> div_cnt_ff == $past(div_cnt_ff))
    else $error("divider moved with reference stopped");
  bad_mul_a: assert property (
    mode_wr_i && mode_wdata_i.pll_en && !mul_ok |=> $stable(mode_ff))
    else $error("illegal multiplier accepted");
  mode_store_a: assert property (
    mode_acc |=> mode_ff == $past(mode_wdata_i))
    else $error("mode not stored");
  run_lock_a: assert property (
    lock_ff |-> run_ff && mode_ff.pll_en)
    else $error("lock without PLL enabled");
  pll_follow_a: assert property (
    on_pll |=> clk_out_ff == $past(pll_lvl))
    else $error("output not following PLL");
  relock_a: assert property (
    pll_entry |=> run_ff && !lock_ff)
    else $error("lock kept across a new PLL write");
  lock_bound_a: assert property (
    (state_ff == cmg_pkg::ST_LOCK) |-> (lock_cnt_ff < LOCK_CYCLES))
    else $error("lock counter beyond lock interval");
  lock_source_a: assert property (
    $rose(lock_ff) |->
      ($past(state_ff) == cmg_pkg::ST_LOCK) && $past(cnt_done))
    else $error("lock without expired counter");
  lock_hold_a: assert property (
    lock_ff && !mode_acc |=> lock_ff)
    else $error("lock dropped without a write");
  leave_pll_a: assert property (
    mode_acc && !mode_wdata_i.pll_en |=> !run_ff && !lock_ff)
    else $error("PLL kept after disable write");
  div4_hold_a: assert property (
    !on_pll && mode_ff.div4 && ref_rise && !div_wrap |=> $stable(clk_out_ff))
    else $error("divide by four toggled early");
  div_range_a: assert property (
    !on_pll |-> div_cnt_ff <= 2'h1)
    else $error("divider count out of range");

  // ****************************************************************
  // Coverage
  // ****************************************************************
  cv_lock_c:  cover property (pll_entry ##[1:400] lock_ff);
  cv_div4_c:  cover property (mode_ff.div4 && ref_rise && div_wrap);
  cv_leave_c: cover property (lock_ff ##1 !run_ff);
  cv_relock_c: cover property (lock_ff && pll_entry);
  cv_refuse_c: cover property (mode_wr_i && mode_wdata_i.pll_en && !mul_ok);
endmodule

// *** sim/cmg_ref_model.sv ***
`timescale 1ns/100ps
// ****
// Reference source and PLL output
// ****
module cmg_ref_model (
  input  wire logic       run_i,    // Reference running
  input  wire logic       pll_en_i, // PLL enabled
  input  wire logic [3:0] mul_i,    // Integer factor
  output logic            ref_o,    // Reference clock
  output logic            pll_o     // PLL output
);
  localparam int unsigned REF_HALF = 800;
  initial begin
    ref_o = 1'b0;
    pll_o = 1'b0;
  end
  // Stopped reference stands still
  always begin
    #(REF_HALF);
    if (run_i) ref_o = ~ref_o;
  end
  // Locks at once, inside the lock bound; low while off
  always begin
    // Unknown or zero factor falls back to the reference rate
    if (mul_i > 4'h0) #(REF_HALF / mul_i);
    else #(REF_HALF);
    pll_o = pll_en_i ? ~pll_o : 1'b0;
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
  localparam int unsigned LOCK = 200;
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  logic               wr = 1'b0;
  cmg_pkg::cmg_mode_s wd = '0;
  cmg_pkg::cmg_mode_s mode;
  logic               run = 1'b1;
  logic               ref_c, pll_c, prun, lck, mco;
  int                 miscompares = 0;
  int                 cmp_count = 0;
  always #50 clk = ~clk;
  cmg_ref_model mdl_u (.run_i(run), .pll_en_i(prun), .mul_i(mode.mul_int),
    .ref_o(ref_c), .pll_o(pll_c));
  cmg_clock_mode_gen #(.LOCK_CYCLES(LOCK)) dut_u (.core_clk_i(clk),
    .srst_i(srst), .ref_clock_pin_i(ref_c), .pll_clk_i(pll_c),
    .mode_wr_i(wr), .mode_wdata_i(wd), .clock_mode_register_o(mode),
    .pll_run_o(prun), .pll_locked_o(lck), .machine_clock_output_o(mco));
  // ****
  // Shared tasks
  // ****
  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask
  task automatic wr_mode(input logic [7:0] m);
    @(posedge clk);
    wr <= 1'b1;
    wd <= m;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  // Cycles from one output rise to the next
  task automatic meas(output int n);
    int i;
    int j;
    for (i = 0; i < 300 && mco !== 1'b0; i++) @(negedge clk);
    for (j = 0; j < 300 && mco !== 1'b1; j++) @(negedge clk);
    for (n = 0; n < 300 && mco !== 1'b0; n++) @(negedge clk);
    for (; n < 300 && mco !== 1'b1; n++) @(negedge clk);
    if (i >= 300 || j >= 300 || n >= 300) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_div;
    int n;
    chk(mode, 8'h00);
    chk({prun, lck}, 2'b00);
    meas(n);
    chk(n, 32);
    wr_mode(8'h80);
    meas(n);
    chk(n, 64);
  endtask
  task automatic t_pll;
    int n;
    wr_mode(8'h50);
    chk({mode, prun}, {8'h50, 1'b1});
    for (n = 0; n < LOCK + 9 && lck !== 1'b1; n++) @(negedge clk);
    chk(n, LOCK);
    meas(n);
    chk(n, 4);
    wr_mode(8'h50);
    meas(n);
    chk(n, 32);
    chk(lck, 1'b0);
    wr_mode(8'h00);
    chk({prun, lck}, 2'b00);
  endtask
  task automatic t_frac;
    for (int f = 1; f < 4; f++) begin
      wr_mode(8'h48 | f[7:0]);
      chk(mode, 8'h48 | f[7:0]);
    end
    wr_mode(8'h40);
    chk(mode, 8'h4b);
    wr_mode(8'h00);
  endtask
  task automatic t_static;
    int n;
    logic h;
    run <= 1'b0;
    repeat (40) @(negedge clk);
    h = mco;
    n = 0;
    repeat (200) begin
      @(negedge clk);
      if (mco !== h) n++;
    end
    chk(n, 0);
    run <= 1'b1;
    meas(n);
    chk(n, 32);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    t_div();
    t_pll();
    t_frac();
    t_static();
    tally_and_finish();
  end
endmodule
